// ==== hw/right_headphone_mix_regs.vh ====
// Register offsets, field positions, reset values and timing for the right headphone mixer bank
`ifndef RIGHT_HEADPHONE_MIX_REGS_VH
`define RIGHT_HEADPHONE_MIX_REGS_VH

// Register offsets
`define OFS_LEFT_AMP_TO_RIGHT_MAIN_HP 8'h3c
`define OFS_LEFT_DAC_TO_RIGHT_MAIN_HP 8'h3d
`define OFS_RIGHT_LINE_TO_RIGHT_MAIN_HP 8'h3e
`define OFS_RIGHT_AMP_TO_RIGHT_MAIN_HP 8'h3f
`define OFS_RIGHT_DAC_TO_RIGHT_MAIN_HP 8'h40
`define OFS_RIGHT_MAIN_HP_LEVEL_CTRL 8'h41
`define OFS_LEFT_LINE_TO_RIGHT_COMMON_HP 8'h42
`define OFS_LEFT_AMP_TO_RIGHT_COMMON_HP 8'h43
`define OFS_LEFT_DAC_TO_RIGHT_COMMON_HP 8'h44
`define OFS_RIGHT_LINE_TO_RIGHT_COMMON_HP 8'h45
`define OFS_RIGHT_AMP_TO_RIGHT_COMMON_HP 8'h46

// Path numbering
`define NUM_PATHS 11
`define NUM_MAIN_PATHS 5
`define PATH_NONE 4'hf

// Source-to-driver register fields
`define ROUTE_BIT 7
`define VOL_MSB 6
`define VOL_LSB 0
`define ROUTE_RESET 1'h0
`define VOL_RESET 7'h00

// Level control register fields
`define LEVEL_MSB 7
`define LEVEL_LSB 4
`define UNMUTE_BIT 3
`define PD_HIZ_BIT 2
`define GAIN_PEND_BIT 1
`define PWR_UP_BIT 0
`define LEVEL_RESET 4'h0
`define UNMUTE_RESET 1'h0
`define PD_HIZ_RESET 1'h1
`define GAIN_PEND_RESET 1'h1
`define PWR_UP_RESET 1'h0

// Gain stepping timing
`define CLK_PERIOD_NS 100
`define GAIN_STEP_NS 1000

`endif

// ==== hw/right_headphone_mix_regs.v ====
// Register bank and gain stepping for the right headphone mixers
`timescale 1ns/1ps
`include "right_headphone_mix_regs.vh"

module right_headphone_mix_regs (
  // Clock and reset
  input wire MCLK_I,
  input wire RST_B_I,
  // Register port
  input wire [7:0] ADDR_I,
  input wire [7:0] WR_DATA_I,
  input wire WR_STB_I,
  input wire RD_STB_I,
  output reg [7:0] RD_DATA_O,
  // Mixer path controls, route bit k and volume bits 7k+6:7k are path k
  output reg [10:0] ROUTE_EN_O,
  output reg [76:0] VOL_APPLIED_O,
  // Right main headphone driver controls
  output reg [3:0] MAIN_LEVEL_O,
  output reg MAIN_UNMUTE_O,
  output reg MAIN_PD_HIZ_O,
  output reg MAIN_PWR_UP_O,
  output reg MAIN_GAIN_PEND_O
);

  localparam integer STEP_CYC_INT =
    (`GAIN_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [31:0] STEP_LAST_INT = STEP_CYC_INT - 1;
  localparam [3:0] STEP_LAST = STEP_LAST_INT[3:0];

  // Maps an offset to a path number, or none
  function [3:0] path_sel;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_LEFT_AMP_TO_RIGHT_MAIN_HP: path_sel = 4'h0;
        `OFS_LEFT_DAC_TO_RIGHT_MAIN_HP: path_sel = 4'h1;
        `OFS_RIGHT_LINE_TO_RIGHT_MAIN_HP: path_sel = 4'h2;
        `OFS_RIGHT_AMP_TO_RIGHT_MAIN_HP: path_sel = 4'h3;
        `OFS_RIGHT_DAC_TO_RIGHT_MAIN_HP: path_sel = 4'h4;
        `OFS_LEFT_LINE_TO_RIGHT_COMMON_HP: path_sel = 4'h5;
        `OFS_LEFT_AMP_TO_RIGHT_COMMON_HP: path_sel = 4'h6;
        `OFS_LEFT_DAC_TO_RIGHT_COMMON_HP: path_sel = 4'h7;
        `OFS_RIGHT_LINE_TO_RIGHT_COMMON_HP: path_sel = 4'h8;
        `OFS_RIGHT_AMP_TO_RIGHT_COMMON_HP: path_sel = 4'h9;
        default: path_sel = `PATH_NONE;
      endcase
    end
  endfunction

  // True for the main driver level register
  function level_sel;
    input [7:0] addr;
    begin
      level_sel = (addr == `OFS_RIGHT_MAIN_HP_LEVEL_CTRL);
    end
  endfunction

  // Reset release through two flops
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_q <= 1'h0;
      rst_sync_q <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // Decoded access
  wire [3:0] wr_path = WR_STB_I ? path_sel(ADDR_I) : `PATH_NONE;
  wire [3:0] rd_path = path_sel(ADDR_I);
  wire wr_level = WR_STB_I && level_sel(ADDR_I);
  wire rd_level = level_sel(ADDR_I);

  // Gain step tick
  reg [3:0] step_cnt_q;
  reg step_tick_q;
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_q <= 4'h0;
      step_tick_q <= 1'h0;
    end else if (step_cnt_q == STEP_LAST) begin
      step_cnt_q <= 4'h0;
      step_tick_q <= 1'h1;
    end else begin
      step_cnt_q <= step_cnt_q + 4'h1;
      step_tick_q <= 1'h0;
    end
  end

  // Routing bits
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ROUTE_EN_O <= {`NUM_PATHS{`ROUTE_RESET}};
    end else begin
      if (wr_path == 4'h0) ROUTE_EN_O[0] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h1) ROUTE_EN_O[1] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h2) ROUTE_EN_O[2] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h3) ROUTE_EN_O[3] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h4) ROUTE_EN_O[4] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h5) ROUTE_EN_O[5] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h6) ROUTE_EN_O[6] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h7) ROUTE_EN_O[7] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h8) ROUTE_EN_O[8] <= WR_DATA_I[`ROUTE_BIT];
      if (wr_path == 4'h9) ROUTE_EN_O[9] <= WR_DATA_I[`ROUTE_BIT];
    end
  end

  // Programmed and applied volume per path; applied steps one code per tick
  reg [6:0] vol_q [0:10];
  reg [6:0] app_q [0:10];
  wire [10:0] mismatch;
  genvar k;
  generate
    for (k = 0; k < 10; k = k + 1) begin : g_path
      always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
          vol_q[k] <= `VOL_RESET;
          app_q[k] <= `VOL_RESET;
        end else begin
          if ({28'h0, wr_path} == k) begin
            vol_q[k] <= WR_DATA_I[`VOL_MSB:`VOL_LSB];
          end
          if (step_tick_q && (app_q[k] < vol_q[k])) begin
            app_q[k] <= app_q[k] + 7'h01;
          end else if (step_tick_q && (app_q[k] > vol_q[k])) begin
            app_q[k] <= app_q[k] - 7'h01;
          end
        end
      end
      assign mismatch[k] = (app_q[k] != vol_q[k]);
      always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
          VOL_APPLIED_O[7*k+6:7*k] <= `VOL_RESET;
        end else begin
          VOL_APPLIED_O[7*k+6:7*k] <= app_q[k];
        end
      end
    end
  endgenerate

  // Slot 10 is unused by any offset; held at reset value
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      vol_q[10] <= `VOL_RESET;
      app_q[10] <= `VOL_RESET;
      VOL_APPLIED_O[76:70] <= `VOL_RESET;
    end else begin
      vol_q[10] <= `VOL_RESET;
      app_q[10] <= `VOL_RESET;
      VOL_APPLIED_O[76:70] <= `VOL_RESET;
    end
  end
  assign mismatch[10] = 1'h0;

  // Main driver level control
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MAIN_LEVEL_O <= `LEVEL_RESET;
      MAIN_UNMUTE_O <= `UNMUTE_RESET;
      MAIN_PD_HIZ_O <= `PD_HIZ_RESET;
      MAIN_PWR_UP_O <= `PWR_UP_RESET;
    end else if (wr_level) begin
      MAIN_LEVEL_O <= WR_DATA_I[`LEVEL_MSB:`LEVEL_LSB];
      MAIN_UNMUTE_O <= WR_DATA_I[`UNMUTE_BIT];
      MAIN_PD_HIZ_O <= WR_DATA_I[`PD_HIZ_BIT];
      MAIN_PWR_UP_O <= WR_DATA_I[`PWR_UP_BIT];
    end
  end

  // Pending while any main path has not reached its programmed gain
  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MAIN_GAIN_PEND_O <= `GAIN_PEND_RESET;
    end else begin
      MAIN_GAIN_PEND_O <= |mismatch[`NUM_MAIN_PATHS-1:0];
    end
  end

  // Read data, valid only in the cycle after the strobe
  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    if (rd_level) begin
      rd_d[`LEVEL_MSB:`LEVEL_LSB] = MAIN_LEVEL_O;
      rd_d[`UNMUTE_BIT] = MAIN_UNMUTE_O;
      rd_d[`PD_HIZ_BIT] = MAIN_PD_HIZ_O;
      rd_d[`GAIN_PEND_BIT] = MAIN_GAIN_PEND_O;
      rd_d[`PWR_UP_BIT] = MAIN_PWR_UP_O;
    end else if (rd_path != `PATH_NONE) begin
      rd_d = {ROUTE_EN_O[rd_path], vol_q[rd_path]};
    end
  end

  always @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA_O <= 8'h00;
    end else if (RD_STB_I) begin
      RD_DATA_O <= rd_d;
    end else begin
      RD_DATA_O <= 8'h00;
    end
  end

endmodule

// ==== verification/right_headphone_mix_regs_chk.sv ====
// Port assertions for the right headphone mixer register bank
`timescale 1ns/1ps
module mix_regs_chk (
  // Clock, reset and bus
  input wire MCLK_I,
  input wire RST_B_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WR_DATA_I,
  input wire WR_STB_I,
  input wire RD_STB_I,
  // Outputs
  input wire [7:0] RD_DATA_O,
  input wire [10:0] ROUTE_EN_O,
  input wire [76:0] VOL_APPLIED_O,
  input wire [3:0] MAIN_LEVEL_O,
  input wire MAIN_UNMUTE_O,
  input wire MAIN_PD_HIZ_O,
  input wire MAIN_PWR_UP_O,
  input wire MAIN_GAIN_PEND_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  wire [7:0] pidx = (ADDR_I < 8'h41) ? ADDR_I - 8'h3c : ADDR_I - 8'h3d;
  wire path_wr = WR_STB_I && ADDR_I >= 8'h3c && ADDR_I <= 8'h46 && ADDR_I != 8'h41;
  wire unmap = ADDR_I < 8'h3c || ADDR_I > 8'h46;
  route_wr_a: assert property (
    path_wr |=> ROUTE_EN_O[$past(pidx)] == $past(WR_DATA_I[7]))
    else $error("route bit missed write");
  level_wr_a: assert property (
    WR_STB_I && ADDR_I == 8'h41 |=> {MAIN_LEVEL_O, MAIN_UNMUTE_O, MAIN_PD_HIZ_O,
    MAIN_PWR_UP_O} == {$past(WR_DATA_I[7:2]), $past(WR_DATA_I[0])})
    else $error("level fields missed write");
  rd_idle_a: assert property (!$past(RD_STB_I) |-> RD_DATA_O == 8'h00)
    else $error("read data outside slot");
  rd_level_a: assert property (
    RD_STB_I && ADDR_I == 8'h41 |=> RD_DATA_O == {$past(MAIN_LEVEL_O), $past(MAIN_UNMUTE_O),
    $past(MAIN_PD_HIZ_O), $past(MAIN_GAIN_PEND_O), $past(MAIN_PWR_UP_O)})
    else $error("level read wrong");
  rd_unmap_a: assert property (RD_STB_I && unmap |=> RD_DATA_O == 8'h00)
    else $error("unmapped read not zero");
  vol_step_a: assert property ($changed(VOL_APPLIED_O) |=> $stable(VOL_APPLIED_O) [*8])
    else $error("volume stepped too fast");
  pend_rise_a: assert property ($rose(MAIN_GAIN_PEND_O) |-> $past(path_wr, 2))
    else $error("pending rose without write");
  pend_ro_a: assert property (
    WR_STB_I && ADDR_I == 8'h41 && !MAIN_GAIN_PEND_O && !$past(path_wr)
    |=> !MAIN_GAIN_PEND_O) else $error("status bit took write");
  cover property (WR_STB_I && ADDR_I == 8'h41);
  cover property ($rose(MAIN_GAIN_PEND_O));
  cover property (RD_STB_I && unmap);
endmodule
bind right_headphone_mix_regs mix_regs_chk mix_regs_chk_i (.MCLK_I, .RST_B_I, .ADDR_I,
  .WR_DATA_I, .WR_STB_I, .RD_STB_I, .RD_DATA_O, .ROUTE_EN_O, .VOL_APPLIED_O, .MAIN_LEVEL_O,
  .MAIN_UNMUTE_O, .MAIN_PD_HIZ_O, .MAIN_PWR_UP_O, .MAIN_GAIN_PEND_O);

// ==== verification/testbench.sv ====
// Self-checking bench for the right headphone mixer register bank
`timescale 1ns/1ps
module testbench;
  reg clk, rst_b, wr_stb, rd_stb;
  reg [7:0] addr, wdata;
  wire [7:0] rdata;
  wire [10:0] route;
  wire [76:0] vol;
  wire [3:0] level;
  wire unmute, pd_hiz, pwr_up, pend;
  integer num_errors = 0, checks_done = 0, i, p, n;
  reg [76:0] exp_vol;
  right_headphone_mix_regs right_headphone_mix_regs_i (.MCLK_I(clk), .RST_B_I(rst_b),
    .ADDR_I(addr), .WR_DATA_I(wdata), .WR_STB_I(wr_stb), .RD_STB_I(rd_stb), .RD_DATA_O(rdata),
    .ROUTE_EN_O(route), .VOL_APPLIED_O(vol), .MAIN_LEVEL_O(level), .MAIN_UNMUTE_O(unmute),
    .MAIN_PD_HIZ_O(pd_hiz), .MAIN_PWR_UP_O(pwr_up), .MAIN_GAIN_PEND_O(pend));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chkv(input logic [76:0] g, input logic [76:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: vector %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  function automatic [7:0] pd(input integer k);
    pd = (k % 2 ? 8'h00 : 8'h80) + k + 1;
  endfunction
  // Wait for applied volumes to reach the programmed ones, then status idle
  task settle;
    n = 0;
    while (vol !== exp_vol && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chkv(vol, exp_vol);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, pend}, 8'h00);
  endtask
  task t_reset;
    for (i = 0; i < 11; i++) rd_chk(8'h3c + i, i == 5 ? 8'h04 : 8'h00);
  endtask
  task t_paths;
    exp_vol = 77'h0;
    for (p = 0; p < 10; p++) begin
      wr(p < 5 ? 8'h3c + p : 8'h3d + p, pd(p));
      exp_vol[7 * p +: 7] = p + 1;
    end
    #1 chkv({66'h0, route}, 77'h155);
    settle;
    for (p = 0; p < 10; p++) rd_chk(p < 5 ? 8'h3c + p : 8'h3d + p, pd(p));
  endtask
  task t_level;
    wr(8'h41, 8'h9b);
    #1 chk({level, unmute, pd_hiz, pend, pwr_up}, 8'h99);
    rd_chk(8'h41, 8'h99);
    wr(8'h41, 8'h64);
    #1 chk({level, unmute, pd_hiz, pend, pwr_up}, 8'h64);
  endtask
  task t_unmap;
    wr(8'h3b, 8'hff);
    wr(8'h47, 8'hff);
    rd_chk(8'h3b, 8'h00);
    rd_chk(8'h47, 8'h00);
    chkv({66'h0, route}, 77'h155);
    for (p = 1; p < 10; p += 2) begin
      wr(p < 5 ? 8'h3c + p : 8'h3d + p, pd(p) | 8'h80);
    end
    #1 chkv({66'h0, route}, 77'h3ff);
    rd_chk(8'h3d, 8'h82);
  endtask
  task t_pend;
    wr(8'h3c, 8'h85);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, pend}, 8'h01);
    wr(8'h41, 8'h04);
    rd_chk(8'h41, 8'h06);
    exp_vol[6:0] = 7'h05;
    settle;
  endtask
  task test_done;
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    test_done;
  end
  initial begin
    {rst_b, wr_stb, rd_stb, addr, wdata} = 19'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk({level, unmute, pd_hiz, pend, pwr_up}, 8'h06);
    repeat (4) @(posedge clk);
    t_reset;
    t_paths;
    t_level;
    t_unmap;
    t_pend;
    test_done;
  end
endmodule
